// file: pkg/hlhdr_pkg.sv
// Purpose: constants for the host link data frame header framer
// Assumes: one 10 MHz clock, registers over AHB-Lite
// Notes:   offsets are byte addresses of aligned words
// Behaviour
// R1 - top header bit separates control from data
// R2 - control frame carries no octets after header
// R3 - sequence break bit marks stream discontinuity
// R4 - originator bit zero from host, one from node
// R5 - message start only in first frame
// R6 - message end only in last frame
// R7 - host echoes reflect frames unchanged
// R8 - host never sets reflect bit
// R9 - low ten bits count following octets
// R10 - on break drop partial, discard until start
// R11 - node sends break when level comes up
// R12 - host resends whole message after loss
// R13 - originator bit checked to catch loopback
// R14 - short or control message: single frame both bits
// R15 - leader start only, middle none, last end
// R16 - node drops packet delimiter violations, reports error
// R17 - message mode frames carry both delimiters
// R18 - count filled in, only counted octets used
// R19 - leader count is ten or twelve
// R20 - middle counts even 2..126, seven at most
// R21 - final frame count from 1 to 125
// R22 - message mode count from 10 to 1019
// R23 - bad count drops frame and reports error
// R24 - packet mode information part at most 128
// R25 - header follows link octets, high octet first
package hlhdr_pkg;
   // *****************************
   // register map
   // *****************************
   localparam logic [7:0]  CTRL_OFS  = 8'h00;
   localparam logic [7:0]  STAT_OFS  = 8'h04;
   localparam logic [7:0]  LHDR_OFS  = 8'h08;
   localparam logic [7:0]  ERR_OFS   = 8'h0c;
   localparam logic [7:0]  DROP_OFS  = 8'h10;
   localparam logic [1:0]  CTRL_RST  = 2'h0;
   localparam int          CTRL_MSG  = 0;
   localparam int          CTRL_UP   = 1;
   // *****************************
   // header layout
   // *****************************
   localparam int          BIT_CTRL  = 15;
   localparam int          BIT_SEQ   = 14;
   localparam int          BIT_ORIG  = 13;
   localparam int          BIT_SOM   = 12;
   localparam int          BIT_EOM   = 11;
   localparam int          BIT_REFL  = 10;
   // *****************************
   // octet count limits
   // *****************************
   localparam logic [10:0] LEAD_NT0  = 11'h00a;
   localparam logic [10:0] LEAD_T0   = 11'h00c;
   localparam logic [10:0] MID_MIN   = 11'h002;
   localparam logic [10:0] MID_MAX   = 11'h07e;
   localparam logic [10:0] LAST_MIN  = 11'h001;
   localparam logic [10:0] LAST_MAX  = 11'h07d;
   localparam logic [10:0] MSG_MIN   = 11'h00a;
   localparam logic [10:0] MSG_MAX   = 11'h3fb;
   localparam logic [10:0] INFO_MAX  = 11'h080;
   localparam logic [10:0] HDR_OCT   = 11'h002;
   localparam logic [2:0]  MID_FRMS  = 3'h7;
   typedef enum logic [1:0] {RX_HI = 2'b00, RX_LO = 2'b01, RX_BODY = 2'b10} hlhdr_rx_e;
endpackage

// file: rtl/hlhdr_framer.sv
// Purpose: node side header check on receive, header build on transmit
// Assumes: receive octets arrive on the same clock, one per valid
// Notes:   verdict pulses one cycle after the last octet of a frame
`timescale 1ns/100ps
module hlhdr_framer
(
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        rxValid,
   input  wire logic [7:0]  rxData,
   input  wire logic        rxLast,
   output logic             pldValid,
   output logic [7:0]       pldData,
   output logic             ctrlFrameSeen,
   output logic             dataAccept,
   output logic             dataDrop,
   output logic             errInData,
   output logic             flushBuffered,
   output logic             loopbackSeen,
   output logic             reflectSeen,
   input  wire logic        txReq,
   input  wire logic        txMsgStart,
   input  wire logic        txMsgEnd,
   input  wire logic        txReflect,
   input  wire logic [9:0]  txCount,
   output logic [15:0]      txHeader,
   output logic             txHeaderValid
);
   // *****************************
   // register bus slave
   // *****************************
   logic [1:0]  ctrlReg;
   logic        wrPendReg;
   logic [7:0]  wrAddrReg;
   logic [15:0] lastHdrReg;
   logic [15:0] errCntReg;
   logic [15:0] dropCntReg;
   logic        discardReg;
   logic        inMsgReg;
   logic [2:0]  midCntReg;
   logic        addrTaken;
   logic        msgMode;
   logic        levelUp;

   assign addrTaken = hready & hsel & htrans[1];
   assign msgMode   = ctrlReg[hlhdr_pkg::CTRL_MSG];
   assign levelUp   = ctrlReg[hlhdr_pkg::CTRL_UP];

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
      end
      else
      begin
         // zero wait state, always OKAY
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wrPendReg <= 1'b0;
         wrAddrReg <= 8'h00;
      end
      else if (hready)
      begin
         wrPendReg <= addrTaken & hwrite;
         wrAddrReg <= haddr;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         ctrlReg <= hlhdr_pkg::CTRL_RST;
      else if (wrPendReg && hready && wrAddrReg == hlhdr_pkg::CTRL_OFS)
         ctrlReg <= hwdata[1:0];
   end

   // read data is latched in the address phase so it stands in the data phase
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         hrdata <= 32'h00000000;
      else if (addrTaken && !hwrite)
      begin
         case (haddr)
            hlhdr_pkg::CTRL_OFS: hrdata <= {30'h00000000, ctrlReg};
            hlhdr_pkg::STAT_OFS: hrdata <= {27'h0000000, midCntReg, inMsgReg, discardReg};
            hlhdr_pkg::LHDR_OFS: hrdata <= {16'h0000, lastHdrReg};
            hlhdr_pkg::ERR_OFS:  hrdata <= {16'h0000, errCntReg};
            hlhdr_pkg::DROP_OFS: hrdata <= {16'h0000, dropCntReg};
            default:             hrdata <= 32'h00000000;
         endcase
      end
   end

   // *****************************
   // receive header parse
   // *****************************
   hlhdr_pkg::hlhdr_rx_e stateReg;
   logic [7:0]  hdrHiReg;
   logic [15:0] hdrReg;
   logic [10:0] physReg;
   logic [15:0] hdr;
   logic [10:0] phys;
   logic [10:0] cnt;
   logic        endNow;
   logic        runt;
   logic        isCtrl, seqB, orig, message_start_flag, message_end_flag;
   logic        looped, inMsgEff, discEff, silent;
   logic        fmtOk, cntOk, accept, reject;
   logic        levelPrevReg;
   logic        levelFall;

   assign levelFall = levelPrevReg & ~levelUp;

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         stateReg <= hlhdr_pkg::RX_HI;
         hdrHiReg <= 8'h00;
         hdrReg   <= 16'h0000;
         physReg  <= 11'h000;
      end
      else if (rxValid)
      begin
         case (stateReg)
            hlhdr_pkg::RX_HI:
            begin
               hdrHiReg <= rxData; // R25
               physReg  <= 11'h000;
               stateReg <= rxLast ? hlhdr_pkg::RX_HI : hlhdr_pkg::RX_LO;
            end
            hlhdr_pkg::RX_LO:
            begin
               hdrReg   <= {hdrHiReg, rxData}; // R25
               stateReg <= rxLast ? hlhdr_pkg::RX_HI : hlhdr_pkg::RX_BODY;
            end
            hlhdr_pkg::RX_BODY:
            begin
               // saturate so an overlong frame cannot wrap into a legal count
               if (physReg != 11'h7ff)
                  physReg <= physReg + 11'h001;
               if (rxLast)
                  stateReg <= hlhdr_pkg::RX_HI;
            end
            default: stateReg <= hlhdr_pkg::RX_HI;
         endcase
      end
   end

   assign endNow = rxValid & rxLast & (stateReg != hlhdr_pkg::RX_HI);
   assign runt   = rxValid & rxLast & (stateReg == hlhdr_pkg::RX_HI);

   always_comb
   begin
      hdr  = (stateReg == hlhdr_pkg::RX_LO) ? {hdrHiReg, rxData} : hdrReg;
      phys = (stateReg == hlhdr_pkg::RX_BODY && physReg != 11'h7ff) ? physReg + 11'h001 : physReg;
      cnt  = {1'b0, hdr[9:0]}; // R9
      isCtrl   = hdr[hlhdr_pkg::BIT_CTRL]; // R1
      seqB     = hdr[hlhdr_pkg::BIT_SEQ]; // R3
      orig     = hdr[hlhdr_pkg::BIT_ORIG];
      message_start_flag      = hdr[hlhdr_pkg::BIT_SOM];
      message_end_flag      = hdr[hlhdr_pkg::BIT_EOM];
      // a frame bearing the node mark came back to us: loop, not host data
      looped   = orig; // R4 R13
      inMsgEff = inMsgReg & ~seqB; // R3
      discEff  = discardReg | seqB; // R10
      silent   = discEff & ~message_start_flag; // R10
      cntOk    = phys >= cnt; // R18 R23
      fmtOk    = 1'b0;
      if (msgMode)
         fmtOk = message_start_flag && message_end_flag && cnt >= hlhdr_pkg::MSG_MIN && cnt <= hlhdr_pkg::MSG_MAX; // R17 R22
      // compared against the reduced limit so a saturated length cannot wrap past it
      else if (phys <= hlhdr_pkg::INFO_MAX - hlhdr_pkg::HDR_OCT) // R24
      begin
         case ({message_start_flag, message_end_flag})
            2'b11, 2'b10: fmtOk = !inMsgEff
                                  && (cnt == hlhdr_pkg::LEAD_NT0 || cnt == hlhdr_pkg::LEAD_T0); // R14 R15 R19
            2'b00: fmtOk = inMsgEff && !cnt[0] && cnt >= hlhdr_pkg::MID_MIN
                           && cnt <= hlhdr_pkg::MID_MAX && midCntReg < hlhdr_pkg::MID_FRMS; // R15 R20
            2'b01: fmtOk = inMsgEff && cnt >= hlhdr_pkg::LAST_MIN
                           && cnt <= hlhdr_pkg::LAST_MAX; // R6 R15 R21
            default: fmtOk = 1'b0;
         endcase
      end
      accept = endNow & ~isCtrl & ~looped & ~silent & fmtOk & cntOk; // R16
      reject = endNow & ~isCtrl & ~looped & ~silent & ~(fmtOk & cntOk); // R16 R23
   end

   // *****************************
   // message tracking
   // *****************************
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         discardReg <= 1'b0;
         inMsgReg   <= 1'b0;
         midCntReg  <= 3'h0;
      end
      else if (levelFall)
      begin
         // queues emptied when the level drops, nothing half-built survives
         discardReg <= 1'b0; // R11
         inMsgReg   <= 1'b0;
         midCntReg  <= 3'h0;
      end
      else if (endNow && !isCtrl && !looped)
      begin
         if (reject)
         begin
            // drop the rest of a broken message instead of flagging each part
            discardReg <= 1'b1;
            inMsgReg   <= 1'b0;
         end
         else if (silent)
            discardReg <= 1'b1; // R10
         else
         begin
            discardReg <= 1'b0;
            // leader opens, middle keeps, final closes the message
            inMsgReg   <= ~msgMode & ~message_end_flag; // R5 R15
            if (message_start_flag)
               midCntReg <= 3'h0;
            else if (!message_end_flag)
               midCntReg <= midCntReg + 3'h1; // R20
         end
      end
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ctrlFrameSeen <= 1'b0;
         dataAccept    <= 1'b0;
         dataDrop      <= 1'b0;
         errInData     <= 1'b0;
         flushBuffered <= 1'b0;
         loopbackSeen  <= 1'b0;
         reflectSeen   <= 1'b0;
      end
      else
      begin
         ctrlFrameSeen <= endNow & isCtrl & (phys == 11'h000); // R1 R2
         dataAccept    <= accept;
         dataDrop      <= runt | (endNow & ~accept & ~(isCtrl & (phys == 11'h000)));
         errInData     <= reject | runt; // R16 R17 R23
         flushBuffered <= (endNow & ~isCtrl & ~looped & seqB) | levelFall; // R10 R11
         loopbackSeen  <= endNow & looped; // R13
         reflectSeen   <= endNow & ~isCtrl & hdr[hlhdr_pkg::BIT_REFL];
      end
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         lastHdrReg <= 16'h0000;
         errCntReg  <= 16'h0000;
         dropCntReg <= 16'h0000;
      end
      else
      begin
         if (endNow)
            lastHdrReg <= hdr;
         if (reject | runt)
            errCntReg <= errCntReg + 16'h0001;
         if (endNow & silent & ~isCtrl & ~looped)
            dropCntReg <= dropCntReg + 16'h0001;
      end
   end

   // only octets inside the count go downstream
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pldValid <= 1'b0;
         pldData  <= 8'h00;
      end
      else
      begin
         pldValid <= rxValid && stateReg == hlhdr_pkg::RX_BODY && physReg < cnt; // R18
         pldData  <= rxData;
      end
   end

   // *****************************
   // transmit header build
   // *****************************
   logic seqPendReg;
   logic levelRise;
   logic txTake;

   assign levelRise = levelUp & ~levelPrevReg;
   // nothing leaves while the level is down
   assign txTake    = txReq & levelUp;

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         levelPrevReg <= 1'b0;
         seqPendReg   <= 1'b0;
      end
      else
      begin
         levelPrevReg <= levelUp;
         seqPendReg   <= (seqPendReg | levelRise) & ~txTake; // R11
      end
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         txHeader      <= 16'h0000;
         txHeaderValid <= 1'b0;
      end
      else
      begin
         txHeaderValid <= txTake;
         if (txTake)
            txHeader <= {1'b0, seqPendReg | levelRise, 1'b1, txMsgStart | msgMode,
                         txMsgEnd | msgMode, txReflect, txCount}; // R1 R4 R5 R6 R11 R17
      end
   end

   // *****************************
   // checks
   // *****************************
   sequence sDataEnd;
      endNow && !isCtrl && !looped && !silent;
   endsequence

   sequence sPktEnd;
      sDataEnd ##0 !msgMode;
   endsequence

   chk_ctrl_route: assert property (@(posedge ref_clk) disable iff (!resetn) // R1 R2
      endNow && isCtrl && phys == 11'h000 |=> ctrlFrameSeen && !dataAccept && !errInData)
      else $error("control frame not routed");

   chk_tx_origin: assert property (@(posedge ref_clk) disable iff (!resetn) // R4
      txTake |=> txHeaderValid && txHeader[hlhdr_pkg::BIT_ORIG] && !txHeader[hlhdr_pkg::BIT_CTRL])
      else $error("transmit header origin wrong");

   chk_seq_flush: assert property (@(posedge ref_clk) disable iff (!resetn) // R10
      endNow && !isCtrl && !looped && seqB && !message_start_flag |=> flushBuffered && !dataAccept ##1 discardReg)
      else $error("sequence break not honoured");

   chk_discard_hold: assert property (@(posedge ref_clk) disable iff (!resetn) // R10
      endNow && discardReg && !message_start_flag && !isCtrl |=> !dataAccept && !errInData)
      else $error("frame taken while discarding");

   chk_level_seq: assert property (@(posedge ref_clk) disable iff (!resetn) // R11
      $rose(levelUp) && !txTake ##1 txTake[*1] |=> txHeader[hlhdr_pkg::BIT_SEQ])
      else $error("no break after level up");

   chk_count_phys: assert property (@(posedge ref_clk) disable iff (!resetn) // R23
      sDataEnd ##0 (cnt > phys) |=> errInData && !dataAccept)
      else $error("short frame not reported");

   chk_msg_mode: assert property (@(posedge ref_clk) disable iff (!resetn) // R17 R22
      sDataEnd ##0 msgMode && (!message_start_flag || !message_end_flag || cnt > hlhdr_pkg::MSG_MAX) |=> errInData)
      else $error("message mode violation passed");

   chk_mid_even: assert property (@(posedge ref_clk) disable iff (!resetn) // R20
      sPktEnd ##0 !message_start_flag && !message_end_flag && cnt[0] |=> !dataAccept ##1 !inMsgReg)
      else $error("odd middle count passed");

   chk_last_range: assert property (@(posedge ref_clk) disable iff (!resetn) // R21
      sPktEnd ##0 !message_start_flag && message_end_flag && (cnt == 11'h000 || cnt > hlhdr_pkg::LAST_MAX) |=> errInData)
      else $error("final count out of range");

   chk_lead_count: assert property (@(posedge ref_clk) disable iff (!resetn) // R19 R14
      sPktEnd ##0 message_start_flag && cnt != hlhdr_pkg::LEAD_NT0 && cnt != hlhdr_pkg::LEAD_T0 |=> errInData)
      else $error("leader count not ten or twelve");

   chk_info_max: assert property (@(posedge ref_clk) disable iff (!resetn) // R24
      sPktEnd ##0 (phys > hlhdr_pkg::INFO_MAX - hlhdr_pkg::HDR_OCT) |=> !dataAccept)
      else $error("oversize packet frame passed");

   chk_open_msg: assert property (@(posedge ref_clk) disable iff (!resetn) // R15
      dataAccept && !msgMode && !$past(message_start_flag) && !$past(message_end_flag) |-> ##1 inMsgReg)
      else $error("middle frame closed message");
endmodule

// file: testbench/hlhdr_host_model.sv
// Purpose: host end of the link, plays received frames into the framer
// Assumes: one frame at a time, body octets follow a fixed pattern
// Notes:   idle data lines toggle so a stale octet is never taken as fresh
`timescale 1ns/100ps
module hlhdr_host_model
(
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   input  wire logic        sendReq,
   input  wire logic [15:0] sendHdr,
   input  wire logic [10:0] sendLen,
   output logic             sendBusy,
   output logic             rxValid,
   output logic [7:0]       rxData,
   output logic             rxLast,
   input  wire logic [15:0] txHeader,
   input  wire logic        txHeaderValid,
   output logic             loopSeen
);
   logic        busyReg;
   logic [15:0] hdrReg;
   logic [10:0] lenReg;
   logic [10:0] idxReg;

   // a request counts as busy at once so the bench never misses the start
   assign sendBusy = busyReg | sendReq;

   // ***************************
   // frame playout
   // ***************************
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         busyReg <= 1'b0;
         hdrReg  <= 16'h0000;
         lenReg  <= 11'h000;
         idxReg  <= 11'h000;
         rxValid <= 1'b0;
         rxData  <= 8'h00;
         rxLast  <= 1'b0;
      end
      else if (busyReg)
      begin
         rxValid <= 1'b1;
         rxLast  <= (idxReg == lenReg + 11'h001);
         idxReg  <= idxReg + 11'h001;
         busyReg <= (idxReg != lenReg + 11'h001);
         if (idxReg == 11'h000)
            // an echo of a node frame goes back untouched, own frames never ask for reflect
            rxData <= hdrReg[13] ? hdrReg[15:8] : (hdrReg[15:8] & 8'hfb);
         else if (idxReg == 11'h001)
            rxData <= hdrReg[7:0];
         else
            rxData <= idxReg[7:0] ^ 8'h5a;
      end
      else
      begin
         rxValid <= 1'b0;
         rxLast  <= 1'b0;
         rxData  <= ~rxData;
         busyReg <= sendReq;
         hdrReg  <= sendHdr;
         lenReg  <= sendLen;
         idxReg  <= 11'h000;
      end
   end

   // a header without the node's originator mark means our own frame came back
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         loopSeen <= 1'b0;
      else if (txHeaderValid === 1'b1 && txHeader[13] === 1'b0)
         loopSeen <= 1'b1;
   end
endmodule

// file: testbench/test_host_link_data_frame_header.sv
// Purpose: self-checking bench for the data frame header framer
// Assumes: zero wait state register bus, host model on the receive side
// Notes:   verdict pulses are counted per frame and compared afterwards
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
   begin \
      checked++; \
      if ((got) !== (ex)) \
      begin \
         miscompares++; \
         $display("[ERR] %s expected %0h seen %0h", nm, ex, got); \
      end \
   end
module test_host_link_data_frame_header;
   localparam logic [6:0] ACC = 7'h01;
   localparam logic [6:0] DRP = 7'h02;
   localparam logic [6:0] ERR = 7'h06;
   localparam logic [6:0] FLA = 7'h09;
   localparam logic [6:0] FLD = 7'h0a;
   localparam logic [6:0] LOP = 7'h12;
   localparam logic [6:0] CTL = 7'h20;
   localparam logic [6:0] RFL = 7'h52;
   logic        ref_clk, resetn, hsel, hwrite, hreadyout, hresp, rxValid, rxLast, pldValid;
   logic        ctrlFrameSeen, dataAccept, dataDrop, errInData, flushBuffered, loopbackSeen;
   logic        reflectSeen, txReq, txMsgStart, txMsgEnd, txReflect, txHeaderValid;
   logic        sendReq, sendBusy, loopSeen;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  haddr, rxData, pldData;
   logic [9:0]  txCount;
   logic [10:0] sendLen;
   logic [15:0] txHeader, sendHdr;
   logic [31:0] hwdata, hrdata, rd;
   logic [6:0]  pulses;
   int          miscompares;
   int          checked;
   int          pldBad;
   int          cnt [0:7];

   hlhdr_framer u_dut
   (
      .ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .rxValid(rxValid), .rxData(rxData), .rxLast(rxLast),
      .pldValid(pldValid), .pldData(pldData), .ctrlFrameSeen(ctrlFrameSeen), .dataAccept(dataAccept),
      .dataDrop(dataDrop), .errInData(errInData), .flushBuffered(flushBuffered),
      .loopbackSeen(loopbackSeen), .reflectSeen(reflectSeen), .txReq(txReq), .txMsgStart(txMsgStart),
      .txMsgEnd(txMsgEnd), .txReflect(txReflect), .txCount(txCount), .txHeader(txHeader),
      .txHeaderValid(txHeaderValid)
   );

   hlhdr_host_model u_host
   (
      .ref_clk(ref_clk), .resetn(resetn), .sendReq(sendReq), .sendHdr(sendHdr), .sendLen(sendLen),
      .sendBusy(sendBusy), .rxValid(rxValid), .rxData(rxData), .rxLast(rxLast), .txHeader(txHeader),
      .txHeaderValid(txHeaderValid), .loopSeen(loopSeen)
   );

   // ***************************
   // clock and pulse counting
   // ***************************
   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   assign pulses = {reflectSeen, ctrlFrameSeen, loopbackSeen, flushBuffered, errInData, dataDrop, dataAccept};

   always @(posedge ref_clk)
   begin
      for (int i = 0; i < 7; i++)
         if (pulses[i] === 1'b1)
            cnt[i]++;
      if (pldValid === 1'b1)
      begin
         // body octets follow the host pattern, offset by the two header octets
         if (pldData !== (8'(cnt[7] + 2) ^ 8'h5a))
            pldBad++;
         cnt[7]++;
      end
   end

   // ***************************
   // access tasks
   // ***************************
   task automatic waitReady();
      int n;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 100);
      if (hreadyout !== 1'b1)
         miscompares++;
   endtask

   // address phase held until taken, then data phase; read data taken at its end
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      waitReady();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      waitReady();
      rd = hrdata;
   endtask

   task automatic rdChk(input logic [7:0] a, input logic [31:0] ex);
      ahb(1'b0, a, 32'h0);
      `CHK($sformatf("register %0h", a), ex, rd)
      `CHK("hresp", 1'b0, hresp)
   endtask

   task automatic txChk(input logic [2:0] f, input logic [9:0] c, input logic ev, input logic [15:0] eh);
      @(posedge ref_clk);
      txReq <= 1'b1;
      {txMsgStart, txMsgEnd, txReflect} <= f;
      txCount <= c;
      @(posedge ref_clk);
      txReq <= 1'b0;
      @(posedge ref_clk);
      `CHK("txHeaderValid", ev, txHeaderValid)
      if (ev)
         `CHK("txHeader", eh, txHeader)
   endtask

   // flag order in ex: reflect, control, loopback, flush, error, drop, accept
   task automatic runFrame(input logic [15:0] h, input int len, input logic [6:0] ex);
      int n;
      int pld;
      foreach (cnt[i]) cnt[i] = 0;
      pldBad = 0;
      @(posedge ref_clk);
      sendReq <= 1'b1;
      sendHdr <= h;
      sendLen <= 11'(len);
      n = 0;
      do
      begin
         @(posedge ref_clk);
         sendReq <= 1'b0;
         n++;
      end
      while (sendBusy === 1'b1 && n < 2000);
      if (sendBusy === 1'b1)
         miscompares++;
      repeat (4) @(posedge ref_clk);
      for (int i = 0; i < 7; i++)
         `CHK($sformatf("frame %h flag %0d", h, i), int'(ex[i]), cnt[i])
      `CHK("payload data", 0, pldBad)
      pld = (int'(h[9:0]) < len) ? int'(h[9:0]) : len;
      if (ex[0])
         `CHK("payload octets", pld, cnt[7])
   endtask

   task automatic print_verdict();
      if (miscompares == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ***************************
   // main sequence
   // ***************************
   initial
   begin
      resetn = 1'b0;
      {hsel, hwrite, txReq, txMsgStart, txMsgEnd, txReflect, sendReq} = '0;
      {htrans, haddr, hwdata, txCount, sendLen, sendHdr} = '0;
      hsize = 3'b010;
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rdChk(hlhdr_pkg::CTRL_OFS, 32'h0);
      rdChk(hlhdr_pkg::STAT_OFS, 32'h0);
      rdChk(hlhdr_pkg::ERR_OFS, 32'h0);
      rdChk(hlhdr_pkg::DROP_OFS, 32'h0);
      txChk(3'b100, 10'd10, 1'b0, 16'h0);
      ahb(1'b1, hlhdr_pkg::CTRL_OFS, 32'h2);
      rdChk(hlhdr_pkg::CTRL_OFS, 32'h2);
      txChk(3'b100, 10'd10, 1'b1, 16'h700a);
      txChk(3'b000, 10'd126, 1'b1, 16'h207e);
      txChk(3'b011, 10'd5, 1'b1, 16'h2c05);
      runFrame(16'h2c05, 5, RFL);
      runFrame(16'h100c, 12, ACC);
      rdChk(hlhdr_pkg::STAT_OFS, 32'h2);
      runFrame(16'h8000, 0, CTL);
      runFrame(16'h0004, 4, ACC);
      runFrame(16'h0803, 5, ACC);
      runFrame(16'h180a, 10, ACC);
      runFrame(16'h380a, 10, LOP);
      runFrame(16'h0004, 4, ERR);
      runFrame(16'h0004, 4, DRP);
      runFrame(16'h100b, 11, ERR);
      runFrame(16'h100a, 10, ACC);
      runFrame(16'h0003, 3, ERR);
      runFrame(16'h500c, 12, FLA);
      runFrame(16'h0802, 1, ERR);
      runFrame(16'h4004, 4, FLD);
      runFrame(16'h100a, 10, ACC);
      runFrame(16'h007e, 126, ACC);
      for (int i = 0; i < 6; i++)
         runFrame(16'h0002, 2, ACC);
      rdChk(hlhdr_pkg::STAT_OFS, 32'h1e);
      runFrame(16'h087d, 125, ACC);
      runFrame(16'h100c, 12, ACC);
      for (int i = 0; i < 7; i++)
         runFrame(16'h0002, 2, ACC);
      runFrame(16'h0002, 2, ERR);
      runFrame(16'h100a, 10, ACC);
      runFrame(16'h007e, 127, ERR);
      ahb(1'b1, hlhdr_pkg::CTRL_OFS, 32'h3);
      runFrame(16'h1bfb, 1019, ACC);
      runFrame(16'h1809, 9, ERR);
      runFrame(16'h100a, 10, ERR);
      runFrame(16'h1bfb, 1000, ERR);
      txChk(3'b000, 10'd1019, 1'b1, 16'h3bfb);
      foreach (cnt[i]) cnt[i] = 0;
      ahb(1'b1, hlhdr_pkg::CTRL_OFS, 32'h1);
      repeat (3) @(posedge ref_clk);
      `CHK("flush on level fall", 1, cnt[3])
      ahb(1'b1, hlhdr_pkg::CTRL_OFS, 32'h3);
      txChk(3'b000, 10'd20, 1'b1, 16'h7814);
      ahb(1'b1, hlhdr_pkg::ERR_OFS, 32'hffff);
      rdChk(hlhdr_pkg::ERR_OFS, 32'h9);
      rdChk(hlhdr_pkg::LHDR_OFS, 32'h1bfb);
      rdChk(8'h14, 32'h0);
      `CHK("looped header", 1'b0, loopSeen)
      print_verdict();
   end

   // the whole run needs a few thousand cycles; ten times that is a hang
   initial
   begin
      #(30000 * 100);
      miscompares++;
      print_verdict();
   end
endmodule
